// ==== inc/usb_susp_map.vh ====
// register offsets, field positions and timing constants of the suspend/irq block
`ifndef USB_SUSP_MAP_VH
`define USB_SUSP_MAP_VH
// register offsets (byte addresses on the plain port)
`define ADDR_GLOBAL_CONTROL 4'h0
`define ADDR_GLOBAL_EVENTS 4'h1
`define ADDR_GLOBAL_IEN 4'h2
`define ADDR_EP_STATUS 4'h3
`define ADDR_EP_IEN 4'h4
`define ADDR_PRIORITY 4'h5
`define ADDR_STATUS 4'h6
// usb_global_control fields
`define CTL_ENABLE 0
`define CTL_CLOCK_DISABLE 1
`define CTL_DETACH 2
`define CTL_RMWU_ENABLE 3
`define CTL_SEND_RMWU 4
`define CTL_UPRES_ACTIVE 5
`define CTL_GLOBAL_IEN 7
// usb_global_event_flags fields
`define EVT_SUSPEND 0
`define EVT_SOF 1
`define EVT_WAKEUP 2
// per-endpoint status fields
`define EPS_TRANSMIT_COMPLETE_FLAG 0
`define EPS_RXB0 1
`define EPS_RXB1 2
`define EPS_SETUP 3
`define EPS_STALL 4
// reset values
`define CTL_RESET 8'h00
`define IEN_RESET 8'h00
// timing, in microseconds, and clock rate in kHz
`define CLK_KHZ 20000
`define SUSPEND_IDLE_US 3000
`define SUSPEND_MIN_US 5000
`define RESUME_DRIVE_US 10000
`endif

// ==== hdl/usb_event_flag.v ====
// one sticky event flag: hardware set wins over software clear
`timescale 1ns/10ps
`default_nettype none
module usb_event_flag (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // set and clear
  input wire set_i,
  input wire clr_i,
  output reg flag_o
);
  // set has priority so an event in the clearing cycle is kept
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      if (set_i) begin
        flag_o <= 1'b1;
      end else if (clr_i) begin
        flag_o <= 1'b0;
      end
    end
  end
endmodule // usb_event_flag
`default_nettype wire

// ==== hdl/usb_idle_timer.v ====
// saturating counter flagging when a condition held for a number of cycles
`timescale 1ns/10ps
`default_nettype none
module usb_idle_timer #(
  parameter WIDTH = 17,
  parameter [WIDTH-1:0] LIMIT = 17'd60000
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // condition to time
  input wire run_i,
  output wire done_o
);
  reg [WIDTH-1:0] count_reg; // cycles the condition has held
  assign done_o = (count_reg >= LIMIT);
  // restart whenever the condition drops; stop at limit
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (!run_i) begin
        count_reg <= {WIDTH{1'b0}};
      end else if (!done_o) begin
        count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // usb_idle_timer
`default_nettype wire

// ==== hdl/usb_suspend_resume_irq.v ====
// suspend, resume, remote wakeup, detach and usb interrupt collection
// Operation
// R1: suspend detection needs clocks and controller enabled
// R2: idle over 3 ms sets suspend flag
// R3: clearing suspend flag puts pad idle
// R4: pad leaves idle on bus wakeup
// R5: firmware sets clock disable after clearing
// R6: firmware stops clocks in fixed order
// R7: resume detection works with clocks stopped
// R8: bus activity sets wakeup flag, wakes cpu
// R9: firmware restarts clock before clearing disable
// R10: firmware clears suspend flag first on resume
// R11: firmware sets remote wakeup enable on request
// R12: firmware clears suspend then sends remote wakeup
// R13: resume-active flag high while resume signalled
// R14: remote wakeup only after 5 ms suspend
// R15: detach bit floats pull-up reference
// R16: two priority bits give level 0 to 3
// R17: event flags share one usb interrupt
// R18: host ack of IN sets transmit complete
// R19: OUT packet sets bank 0 or 1 flag; a bank 1 OUT sets no flag unless EP_PINGPONG_I is high
// R20: accepted SETUP sets setup received flag
// R21: stall sent sets flag, SETUP clears it; the code sets the flag only while EP_STALL_TYPE_I is high
// R22: start of frame sets frame flag
// R23: firmware clears frame flag after each frame
// R24: irq is OR of enabled flags, global gate
`timescale 1ns/10ps
`include "usb_susp_map.vh"
`default_nettype none
module usb_suspend_resume_irq #(
  parameter NUM_EP = 7,
  parameter CW = 18,
  parameter [CW-1:0] IDLE_CYCLES =
    (`SUSPEND_IDLE_US * (`CLK_KHZ / 1000)) + 1,
  parameter [CW-1:0] SUSP_MIN_CYCLES = `SUSPEND_MIN_US * (`CLK_KHZ / 1000),
  parameter [CW-1:0] RESUME_CYCLES = `RESUME_DRIVE_US * (`CLK_KHZ / 1000)
) (
  // clock, reset, enable
  input wire CLOCK_I,
  input wire RST_I,
  input wire CE_I,
  // register port
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  // bus line state and clock status
  input wire BUS_IDLE_I,
  input wire CLOCKS_RUN_I,
  // endpoint events from the packet engine
  input wire [2:0] EP_SEL_I,
  input wire TX_ACK_I,
  input wire RX_OUT_I,
  input wire RX_BANK1_I,
  input wire EP_PINGPONG_I,
  input wire SETUP_I,
  input wire STALL_SENT_I,
  input wire EP_STALL_TYPE_I,
  input wire SOF_I,
  // outputs to pad, cpu and interrupt controller
  output wire PAD_IDLE_O,
  output wire RESUME_DRIVE_O,
  output wire VREF_OE_O,
  output wire USB_IRQ_O,
  output wire CPU_WAKE_O,
  output wire [1:0] USB_PRIO_O
);
  // control and enable registers
  reg [7:0] ctl_reg; // usb_global_control, bit 5 is hardware owned
  reg [2:0] gien_reg; // per global event enables
  reg [4:0] epien_reg; // per endpoint-flag-type enables
  reg [1:0] prio_reg; // usb_priority_high_bit, usb_priority_low_bit
  reg [2:0] ep_view_reg; // endpoint shown in the status register
  reg pad_idle_reg; // pad in low power mode
  reg resume_reg; // upstream_resume_active
  reg [CW-1:0] res_cnt_reg; // resume signalling length
  wire wr_ctl = WR_I && (ADDR_I == `ADDR_GLOBAL_CONTROL);
  wire wr_evt = WR_I && (ADDR_I == `ADDR_GLOBAL_EVENTS);
  wire wr_eps = WR_I && (ADDR_I == `ADDR_EP_STATUS);
  wire susp_flag, sof_flag, wake_flag; // global sticky flags
  wire idle_long, susp_long; // timer outputs
  // suspend timing only while clocks run and controller enabled
  wire susp_run = BUS_IDLE_I && CLOCKS_RUN_I && ctl_reg[`CTL_ENABLE] &&
    !ctl_reg[`CTL_CLOCK_DISABLE]; // R1
  // bus idle time for the suspend event
  usb_idle_timer #(.WIDTH(CW), .LIMIT(IDLE_CYCLES)) idle_tmr (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .run_i(susp_run),
    .done_o(idle_long)
  );
  // total time in suspend, gating remote wakeup
  usb_idle_timer #(.WIDTH(CW), .LIMIT(SUSP_MIN_CYCLES)) susp_tmr (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .run_i(BUS_IDLE_I && (susp_flag || pad_idle_reg)),
    .done_o(susp_long)
  );
  reg idle_long_d; // edge detect so one idle period sets once
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      idle_long_d <= 1'b0;
    end else if (CE_I) begin
      idle_long_d <= idle_long;
    end
  end
  wire susp_set = idle_long && !idle_long_d; // R2
  wire susp_clr = wr_evt && !WDATA_I[`EVT_SUSPEND];
  usb_event_flag f_susp (
    .clk_i(CLOCK_I), .rst_i(RST_I), .ce_i(CE_I),
    .set_i(susp_set), .clr_i(susp_clr), .flag_o(susp_flag)
  );
  usb_event_flag f_sof (
    .clk_i(CLOCK_I), .rst_i(RST_I), .ce_i(CE_I),
    .set_i(SOF_I), // R22
    .clr_i(wr_evt && !WDATA_I[`EVT_SOF]), // R23
    .flag_o(sof_flag)
  );
  // wakeup is detected combinationally as well, so it works without clock
  wire wake_now = pad_idle_reg && !BUS_IDLE_I; // R7
  usb_event_flag f_wake (
    .clk_i(CLOCK_I), .rst_i(RST_I), .ce_i(CE_I),
    .set_i(wake_now), // R8
    .clr_i(wr_evt && !WDATA_I[`EVT_WAKEUP]),
    .flag_o(wake_flag)
  );
  // pad idle entry on clear of suspend flag, exit on bus activity
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pad_idle_reg <= 1'b0;
    end else if (CE_I) begin
      if (!BUS_IDLE_I) begin
        pad_idle_reg <= 1'b0; // R4
      end else if (susp_clr && susp_flag) begin
        pad_idle_reg <= 1'b1; // R3
      end
    end
  end
  assign PAD_IDLE_O = pad_idle_reg && BUS_IDLE_I; // R4
  // control register, with hardware-owned resume-active bit
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      ctl_reg <= `CTL_RESET;
      gien_reg <= 3'h0;
      epien_reg <= 5'h00;
      prio_reg <= 2'h0;
      ep_view_reg <= 3'h0;
    end else if (CE_I) begin
      if (wr_ctl) begin
        ctl_reg <= WDATA_I;
      end
      if (WR_I && ADDR_I == `ADDR_GLOBAL_IEN) begin
        gien_reg <= WDATA_I[2:0];
      end
      if (WR_I && ADDR_I == `ADDR_EP_IEN) begin
        epien_reg <= WDATA_I[4:0];
      end
      if (WR_I && ADDR_I == `ADDR_PRIORITY) begin
        prio_reg <= WDATA_I[1:0]; // R16
      end
      if (WR_I && ADDR_I == `ADDR_STATUS) begin
        ep_view_reg <= WDATA_I[2:0];
      end
    end
  end
  // upstream resume: send request, enable, 5 ms of suspend, clocks on
  wire res_start = ctl_reg[`CTL_SEND_RMWU] && ctl_reg[`CTL_RMWU_ENABLE] &&
    susp_long && !susp_flag && CLOCKS_RUN_I && !resume_reg; // R14
  reg res_done_reg; // stops retrigger until firmware drops send bit
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      resume_reg <= 1'b0;
      res_cnt_reg <= {CW{1'b0}};
      res_done_reg <= 1'b0;
    end else if (CE_I) begin
      if (!ctl_reg[`CTL_SEND_RMWU]) begin
        res_done_reg <= 1'b0;
      end
      if (res_start && !res_done_reg) begin
        resume_reg <= 1'b1; // R13
        res_cnt_reg <= RESUME_CYCLES;
      end else if (resume_reg) begin
        if (res_cnt_reg <= {{(CW-1){1'b0}}, 1'b1}) begin
          resume_reg <= 1'b0; // R13
          res_done_reg <= 1'b1;
        end else begin
          res_cnt_reg <= res_cnt_reg - {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  assign RESUME_DRIVE_O = resume_reg;
  // detach floats the pull-up reference
  assign VREF_OE_O = !ctl_reg[`CTL_DETACH]; // R15
  // per-endpoint status flags, one array row per endpoint
  reg [4:0] eps_reg [0:NUM_EP-1];
  integer i;
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      for (i = 0; i < NUM_EP; i = i + 1) begin
        eps_reg[i] <= 5'h00;
      end
    end else if (CE_I) begin
      for (i = 0; i < NUM_EP; i = i + 1) begin
        // software clears by writing zeros to the viewed endpoint
        if (wr_eps && ep_view_reg == i[2:0]) begin
          eps_reg[i] <= eps_reg[i] & WDATA_I[4:0];
        end
        if (EP_SEL_I == i[2:0]) begin
          // hardware sets, later in the block so set wins
          if (TX_ACK_I) begin
            eps_reg[i][`EPS_TRANSMIT_COMPLETE_FLAG] <= 1'b1; // R18
          end
          if (RX_OUT_I && !RX_BANK1_I) begin
            eps_reg[i][`EPS_RXB0] <= 1'b1; // R19
          end
          if (RX_OUT_I && RX_BANK1_I && EP_PINGPONG_I) begin
            eps_reg[i][`EPS_RXB1] <= 1'b1; // R19
          end
          if (SETUP_I) begin
            eps_reg[i][`EPS_SETUP] <= 1'b1; // R20
            eps_reg[i][`EPS_STALL] <= 1'b0; // R21
          end else if (STALL_SENT_I && EP_STALL_TYPE_I) begin
            eps_reg[i][`EPS_STALL] <= 1'b1; // R21
          end
        end
      end
    end
  end
  // collect enabled flags into one request
  reg ep_any; // any enabled endpoint flag
  integer j; // own loop index, so no variable is shared with a clocked process
  always @* begin
    ep_any = 1'b0;
    for (j = 0; j < NUM_EP; j = j + 1) begin
      ep_any = ep_any | (|(eps_reg[j] & epien_reg));
    end
  end
  wire glob_any = |({wake_flag, sof_flag, susp_flag} & gien_reg);
  assign USB_IRQ_O = ctl_reg[`CTL_GLOBAL_IEN] && (ep_any || glob_any); // R17 R24
  // wake works from the live bus so a stopped clock cannot block it
  assign CPU_WAKE_O = ctl_reg[`CTL_GLOBAL_IEN] &&
    gien_reg[`EVT_WAKEUP] && (wake_flag || wake_now); // R8
  assign USB_PRIO_O = prio_reg; // R16
  // read data one cycle after the strobe, zero otherwise
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 8'h00;
    end else if (CE_I) begin
      RDATA_O <= 8'h00;
      if (RD_I) begin
        case (ADDR_I)
          `ADDR_GLOBAL_CONTROL: RDATA_O <= {ctl_reg[7:6], resume_reg,
            ctl_reg[4:0]}; // R13
          `ADDR_GLOBAL_EVENTS: RDATA_O <= {5'h00, wake_flag, sof_flag,
            susp_flag};
          `ADDR_GLOBAL_IEN: RDATA_O <= {5'h00, gien_reg};
          `ADDR_EP_STATUS: RDATA_O <= (ep_view_reg < NUM_EP) ?
            {3'h0, eps_reg[ep_view_reg]} : 8'h00;
          `ADDR_EP_IEN: RDATA_O <= {3'h0, epien_reg};
          `ADDR_PRIORITY: RDATA_O <= {6'h00, prio_reg};
          `ADDR_STATUS: RDATA_O <= {pad_idle_reg, susp_long, 3'h0,
            ep_view_reg};
          default: RDATA_O <= 8'h00;
        endcase
      end
    end
  end
endmodule // usb_suspend_resume_irq
`default_nettype wire

// ==== bench/usb_host_model.sv ====
// behavioural upstream host: bus line state and start-of-frame tokens
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // requests from the bench
  input wire logic wake_req_i,
  input wire logic sof_req_i,
  // line state seen by the device
  output logic bus_idle_o,
  output logic sof_o
);
  // non-idle only while asked, so the device sees real J/K changes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_idle_o <= 1'b1;
      sof_o <= 1'b0;
    end else begin
      bus_idle_o <= !wake_req_i;
      sof_o <= sof_req_i; // one token per request
    end
  end
endmodule // usb_host_model
`default_nettype wire

// ==== bench/usb_suspend_resume_irq_asserts.sv ====
// port checks of the suspend, resume and irq block
`timescale 1ns/10ps
`default_nettype none
module usb_suspend_resume_irq_asserts #(
  parameter CW = 18,
  parameter [CW-1:0] SUSP_MIN_CYCLES = 18'd100000
) (
  // clock, reset, register port
  input wire CLOCK_I,
  input wire RST_I,
  input wire CE_I,
  input wire [3:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [7:0] RDATA_O,
  // bus and block outputs
  input wire BUS_IDLE_I,
  input wire PAD_IDLE_O,
  input wire RESUME_DRIVE_O,
  input wire VREF_OE_O,
  input wire USB_IRQ_O,
  input wire CPU_WAKE_O,
  input wire [1:0] USB_PRIO_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // consecutive idle cycles; saturates so a long suspend cannot wrap
  logic [CW-1:0] idle_cnt;
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) idle_cnt <= '0;
    else if (!BUS_IDLE_I) idle_cnt <= '0;
    else if (CE_I && idle_cnt != {CW{1'b1}}) idle_cnt <= idle_cnt + 1'b1;
  end
  // resume drive: eight cycles held, then it must end soon after
  sequence s_drive_hold;
    RESUME_DRIVE_O [*8];
  endsequence
  sequence s_drive_end;
    ##[1:4] !RESUME_DRIVE_O;
  endsequence
  chk_rdata_quiet: assert property ($past(CE_I) && !$past(RD_I)
    |-> RDATA_O == 8'h00) else $error("read data outside read slot");
  chk_detach_float: assert property (WR_I && CE_I && ADDR_I == 4'h0
    |=> VREF_OE_O == !$past(WDATA_I[2])) else $error("vref enable wrong");
  chk_prio_level: assert property (WR_I && CE_I && ADDR_I == 4'h5
    |=> USB_PRIO_O == $past(WDATA_I[1:0])) else $error("priority wrong");
  chk_irq_gate_off: assert property (WR_I && CE_I && ADDR_I == 4'h0
    && !WDATA_I[7] |=> !USB_IRQ_O) else $error("irq with gate off");
  chk_pad_needs_idle: assert property (PAD_IDLE_O |-> BUS_IDLE_I)
    else $error("pad idle on busy bus");
  chk_wake_on_bus: assert property ($past(PAD_IDLE_O) && !BUS_IDLE_I
    |-> CPU_WAKE_O) else $error("no cpu wake on bus activity");
  chk_resume_length: assert property ($rose(RESUME_DRIVE_O)
    |-> s_drive_hold ##0 s_drive_end) else $error("resume length wrong");
  chk_resume_after_min: assert property ($rose(RESUME_DRIVE_O)
    |-> idle_cnt >= SUSP_MIN_CYCLES) else $error("resume too early");
endmodule // usb_suspend_resume_irq_asserts
bind usb_suspend_resume_irq usb_suspend_resume_irq_asserts #(.CW(CW),
  .SUSP_MIN_CYCLES(SUSP_MIN_CYCLES)) usb_suspend_resume_irq_asserts_inst (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .BUS_IDLE_I(BUS_IDLE_I), .PAD_IDLE_O(PAD_IDLE_O),
  .RESUME_DRIVE_O(RESUME_DRIVE_O), .VREF_OE_O(VREF_OE_O),
  .USB_IRQ_O(USB_IRQ_O), .CPU_WAKE_O(CPU_WAKE_O), .USB_PRIO_O(USB_PRIO_O));
`default_nettype wire

// ==== bench/usb_suspend_resume_irq_tb.sv ====
// register-level bench of the suspend, resume and irq block
`timescale 1ns/10ps
`default_nettype none
module usb_suspend_resume_irq_tb;
  // driven inputs
  logic clk, rst, ce, wr, rd, clk_run, wake_req, sof_req;
  logic tx, rxo, bank1, pp, setup, stl, stype;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [2:0] ep;
  // observed outputs
  wire [7:0] rdata;
  wire bus_idle, sof, pad_idle, res_drv, vref_oe, irq, cpu_wake;
  wire [1:0] prio;
  int err_total = 0;
  int checked = 0;
  int i;
  // short counts keep the run small
  usb_suspend_resume_irq #(.IDLE_CYCLES(18'd20), .SUSP_MIN_CYCLES(18'd30),
    .RESUME_CYCLES(18'd10)) usb_suspend_resume_irq_inst (
    .CLOCK_I(clk), .RST_I(rst), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUS_IDLE_I(bus_idle),
    .CLOCKS_RUN_I(clk_run), .EP_SEL_I(ep), .TX_ACK_I(tx), .RX_OUT_I(rxo),
    .RX_BANK1_I(bank1), .EP_PINGPONG_I(pp), .SETUP_I(setup),
    .STALL_SENT_I(stl), .EP_STALL_TYPE_I(stype), .SOF_I(sof),
    .PAD_IDLE_O(pad_idle), .RESUME_DRIVE_O(res_drv), .VREF_OE_O(vref_oe),
    .USB_IRQ_O(irq), .CPU_WAKE_O(cpu_wake), .USB_PRIO_O(prio));
  usb_host_model usb_host_model_inst (.clk_i(clk), .rst_i(rst),
    .wake_req_i(wake_req), .sof_req_i(sof_req), .bus_idle_o(bus_idle),
    .sof_o(sof));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // closing report, reached from the end and from any timeout
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] got,
    input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // bus cycles; each ends just past the edge so results have settled
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp,
    input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp(nm, rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle event pulse: {sof, setup, stall, out, in-ack}
  task automatic ev(input logic [4:0] m);
    @(posedge clk);
    {sof_req, setup, stl, rxo, tx} <= m;
    @(posedge clk);
    {sof_req, setup, stl, rxo, tx} <= 5'h00;
    tick(1);
  endtask
  // bounded wait on the resume drive; a timeout ends the run
  task automatic wait_res(input logic lvl, input int n);
    int k;
    for (k = 0; k < n && res_drv !== lvl; k++) tick(1);
    if (res_drv !== lvl) begin
      cmp("resume wait", {7'h00, res_drv}, {7'h00, lvl});
      end_sim();
    end
  endtask
  initial begin
    {rst, ce, clk_run} = 3'b110;
    {wr, rd, wake_req, sof_req, tx, rxo, bank1, pp, setup, stl} = '0;
    {stype, addr, wdata, ep} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_reg(4'h0, 8'h00, "control reset");
    rd_reg(4'h2, 8'h00, "enables reset");
    cmp("vref reset", {7'h00, vref_oe}, 8'h01);
    wr_reg(4'hf, 8'hff);
    rd_reg(4'hf, 8'h00, "unmapped");
    for (i = 0; i < 4; i++) begin
      wr_reg(4'h5, i[7:0]);
      cmp("priority", {6'h00, prio}, i[7:0]);
    end
    wr_reg(4'h0, 8'h04);
    cmp("vref detach", {7'h00, vref_oe}, 8'h00);
    tick(70);
    wr_reg(4'h0, 8'h00);
    cmp("vref attach", {7'h00, vref_oe}, 8'h01);
    // suspend needs running clocks, then more than the idle time
    clk_run <= 1'b0;
    wr_reg(4'h0, 8'h01);
    tick(40);
    rd_reg(4'h1, 8'h00, "suspend clocks off");
    clk_run <= 1'b1;
    wr_reg(4'h2, 8'h07);
    tick(8);
    rd_reg(4'h1, 8'h00, "suspend early");
    tick(20);
    rd_reg(4'h1, 8'h01, "suspend flag");
    cmp("irq gated", {7'h00, irq}, 8'h00);
    wr_reg(4'h0, 8'h81);
    cmp("irq suspend", {7'h00, irq}, 8'h01);
    // low-power entry, then wake with the clock frozen
    wr_reg(4'h1, 8'h06);
    cmp("pad idle", {7'h00, pad_idle}, 8'h01);
    wr_reg(4'h0, 8'h83);
    clk_run <= 1'b0;
    ce <= 1'b0;
    wake_req <= 1'b1;
    tick(3);
    cmp("cpu wake", {7'h00, cpu_wake}, 8'h01);
    cmp("pad exit", {7'h00, pad_idle}, 8'h00);
    ce <= 1'b1;
    clk_run <= 1'b1;
    wr_reg(4'h0, 8'h81);
    rd_reg(4'h1, 8'h04, "wake flag");
    wake_req <= 1'b0;
    wr_reg(4'h1, 8'h00);
    // remote wakeup from a fresh suspend
    wr_reg(4'h0, 8'h89);
    tick(25);
    rd_reg(4'h1, 8'h01, "suspend again");
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h99);
    wait_res(1'b1, 300);
    rd_reg(4'h0, 8'hb9, "resume active");
    wait_res(1'b0, 50);
    rd_reg(4'h0, 8'h99, "resume done");
    wr_reg(4'h0, 8'h89);
    // endpoint flags on endpoint 2
    clk_run <= 1'b0;
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h4, 8'h1f);
    wr_reg(4'h6, 8'h02);
    ep <= 3'h2;
    stype <= 1'b1;
    ev(5'h01);
    rd_reg(4'h3, 8'h01, "tx complete");
    ev(5'h02);
    rd_reg(4'h3, 8'h03, "rx bank0");
    bank1 <= 1'b1;
    ev(5'h02);
    rd_reg(4'h3, 8'h03, "bank1 no pingpong");
    pp <= 1'b1;
    ev(5'h02);
    rd_reg(4'h3, 8'h07, "rx bank1");
    ev(5'h04);
    rd_reg(4'h3, 8'h17, "stall sent");
    ev(5'h08);
    rd_reg(4'h3, 8'h0f, "setup clears stall");
    wr_reg(4'h4, 8'h00);
    wr_reg(4'h2, 8'h00);
    cmp("irq masked", {7'h00, irq}, 8'h00);
    wr_reg(4'h4, 8'h08);
    cmp("irq setup", {7'h00, irq}, 8'h01);
    rd_reg(4'h6, 8'hc2, "status pad and suspend time");
    ev(5'h10);
    rd_reg(4'h1, 8'h02, "frame flag");
    wr_reg(4'h1, 8'h05);
    rd_reg(4'h1, 8'h00, "frame cleared");
    end_sim();
  end
endmodule // usb_suspend_resume_irq_tb
`default_nettype wire
